// ### design/ocdc_pkg.sv
// output channel divider control: shared constants, types and decoders
// assumes byte-wide configuration accesses at fixed byte addresses
package ocdc_pkg;

  // ==========================================================
  // structure
  localparam int NUM_CHAN = 5;
  localparam int NUM_OUT = 10;

  // ==========================================================
  // register map
  localparam logic [7:0] CHAN_BASE = 8'h20;
  localparam logic [7:0] CHAN_STRIDE = 8'h10;
  localparam logic [7:0] OFF_DIVIDE = 8'h00;
  localparam logic [7:0] OFF_PHASE = 8'h01;
  localparam logic [7:0] OFF_CHAN_PD = 8'h02;
  localparam logic [7:0] ENABLE_ADDR_LO = 8'h74;
  localparam logic [7:0] ENABLE_ADDR_HI = 8'h75;

  // field positions
  localparam int CHAN_PD_BIT = 7;
  localparam int OUT_PD_BIT = 7;
  localparam int STYLE_BIT = 4;
  localparam int AMP_LSB = 2;

  // values after reset
  localparam logic [7:0] DIVIDE_RST = 8'h04;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic PD_RST = 1'b0;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic STYLE_RST = 1'b0;
  localparam logic [1:0] AMP_RST = 2'h0;

  // ==========================================================
  // timing: one phase step, at least one clock cycle
  localparam int CLK_PERIOD_PS = 100000;
  localparam int PHASE_STEP_PS = 339;
  localparam int PHASE_STEP_CYC =
    (PHASE_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } ocdc_state_t;

  typedef enum logic {
    FMT_LOW_VOLT_DIFF = 1'b0,
    FMT_EMITTER_COUPLED = 1'b1
  } ocdc_format_t;

  typedef enum logic [1:0] {
    SWING_250MV = 2'h0,
    SWING_500MV = 2'h1,
    SWING_750MV = 2'h2,
    SWING_1000MV = 2'h3
  } ocdc_swing_t;

  // ==========================================================
  // decoders
  // divider code to ratio; reserved codes fall back to divide by 6
  function automatic logic [7:0] ocdcRatio(input logic [7:0] code);
    case (code)
      8'h80: return 8'h01;
      8'h00: return 8'h02;
      8'h01: return 8'h03;
      8'h02: return 8'h04;
      8'h03: return 8'h05;
      8'h04: return 8'h06;
      8'h06: return 8'h08;
      8'h43: return 8'h0A;
      8'h44: return 8'h0C;
      8'h46: return 8'h10;
      8'h4B: return 8'h14;
      8'h4C: return 8'h18;
      8'h53: return 8'h1E;
      8'h4E: return 8'h20;
      8'h54: return 8'h24;
      8'h5B: return 8'h28;
      8'h56: return 8'h30;
      8'h63: return 8'h32;
      8'h64: return 8'h3C;
      8'h5E: return 8'h40;
      8'h5F: return 8'h48;
      8'h66: return 8'h50;
      8'h6E: return 8'h60;
      8'h7B: return 8'h64;
      8'h7C: return 8'h78;
      8'h76: return 8'h80;
      8'h7E: return 8'hA0;
      default: return 8'h06;
    endcase
  endfunction

  // byte address of a channel register
  function automatic logic [7:0] ocdcChanAddr(input int ch,
                                               input logic [7:0] off);
    return 8'(int'(CHAN_BASE) + int'(CHAN_STRIDE) * ch + int'(off));
  endfunction

  // channel that feeds each output
  function automatic int ocdcOutChan(input int idx);
    case (idx)
      0, 1, 2: return 0;
      3, 4: return 1;
      5, 6: return 2;
      7: return 3;
      default: return 4;
    endcase
  endfunction

  // byte address of each output's settings register
  function automatic logic [7:0] ocdcOutAddr(input int idx);
    case (idx)
      0: return 8'h24;
      1: return 8'h25;
      2: return 8'h26;
      3: return 8'h34;
      4: return 8'h35;
      5: return 8'h44;
      6: return 8'h45;
      7: return 8'h54;
      8: return 8'h64;
      default: return 8'h65;
    endcase
  endfunction

  // enable bit address and position of each output
  function automatic logic [7:0] ocdcEnAddr(input int idx);
    return (idx < 8) ? ENABLE_ADDR_LO : ENABLE_ADDR_HI;
  endfunction

  function automatic int ocdcEnBit(input int idx);
    return (idx < 8) ? (7 - idx) : (idx - 8);
  endfunction

endpackage

// ### design/ocdc_channel_divider.sv
// one channel's integer divider with coarse phase start delay
// assumes ratio and delay are stable while restart is low
`timescale 1ns/1ps

module ocdc_channel_divider
  import ocdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic powerDown,
  input wire logic [7:0] ratio,
  input wire logic [7:0] delay,
  output logic divClk
);

  ocdc_state_t state_q, state_d;
  logic [15:0] waitCnt_q;
  logic [7:0] phaseCnt_q, phaseCnt_d;
  logic [15:0] loadCnt;
  logic [8:0] highCnt;
  logic divClk_q;

  assign loadCnt = 16'(int'(delay) * PHASE_STEP_CYC);
  assign highCnt = (9'(ratio) + 9'h001) >> 1;
  assign divClk = divClk_q;

  // ==========================================================
  // sequencing: off, phase wait, running
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: state_d = (loadCnt == 16'h0000) ? ST_RUN : ST_WAIT;
      ST_WAIT: if (waitCnt_q == 16'h0001) begin
        state_d = ST_RUN;
      end
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_OFF;
    endcase
    if (powerDown) begin
      state_d = ST_OFF;
    end else if (restart) begin
      state_d = (loadCnt == 16'h0000) ? ST_RUN : ST_WAIT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // phase delay countdown in steps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitCnt_q <= 16'h0000;
    end else if (state_d == ST_WAIT &&
                 (state_q != ST_WAIT || restart)) begin
      waitCnt_q <= loadCnt;
    end else if (state_q == ST_WAIT) begin
      waitCnt_q <= waitCnt_q - 16'h0001;
    end
  end

  // ==========================================================
  // divider count, wraps at the ratio
  always_comb begin
    phaseCnt_d = 8'h00;
    if (state_d == ST_RUN && state_q == ST_RUN && !restart) begin
      if (9'(phaseCnt_q) + 9'h001 >= 9'(ratio)) begin
        phaseCnt_d = 8'h00;
      end else begin
        phaseCnt_d = phaseCnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phaseCnt_q <= 8'h00;
    end else begin
      phaseCnt_q <= phaseCnt_d;
    end
  end

  // high for the first half of each period, low when stopped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divClk_q <= 1'b0;
    end else begin
      divClk_q <= (state_d == ST_RUN) && (9'(phaseCnt_d) < highCnt);
    end
  end

  // ==========================================================
  // checks
  sequence startNoDelay;
    restart && !powerDown && delay == 8'h00;
  endsequence

  sequence startOneStep;
    restart && !powerDown && delay == 8'h01;
  endsequence

  chk_phase_zero: assert property (@(posedge clk) disable iff (!rst_n)
    startNoDelay |=> state_q == ST_RUN && phaseCnt_q == 8'h00)
    else $error("zero phase code did not start at once");

  chk_phase_one: assert property (@(posedge clk) disable iff (!rst_n)
    startOneStep |=> state_q == ST_WAIT && !divClk ##1 state_q == ST_RUN)
    else $error("one phase step did not delay one cycle");

  chk_pd_off: assert property (@(posedge clk) disable iff (!rst_n)
    powerDown |=> state_q == ST_OFF && !divClk)
    else $error("powered down channel still runs");

  chk_div_window: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_RUN && $stable(ratio) && !restart && !powerDown &&
    9'(phaseCnt_q) + 9'h001 >= 9'(ratio) |=>
    phaseCnt_q == 8'h00 && divClk)
    else $error("divider period did not wrap to a high start");

endmodule

// ### design/ocdc_control.sv
// What this block does
// - decode each channel's 8-bit divider code to ratio, reset is divide six
// - channel power-down bit one stops whole channel; resets to zero
// - output power-down bit one powers that output down; resets zero
// - channel start delayed by phase code times one-clock-cycle steps (339ps rounded up); resets zero
// - output enable zero holds output low; one passes clock; resets zero
// - format bit zero low-voltage differential, one emitter-coupled
// - two-bit amplitude picks one of four swings; resets to 00
//
// channel and clock output settings registers plus divided outputs
// assumes the configuration port is driven by logic on clk
`timescale 1ns/1ps

module ocdc_control
  import ocdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  output logic [7:0] cfgRdData,
  output logic cfgRdValid,
  output logic [NUM_OUT-1:0] clockOutputPin,
  output logic [NUM_OUT-1:0] outputFormat,
  output logic [2*NUM_OUT-1:0] outputSwing,
  output logic [NUM_OUT-1:0] outputPowerDown,
  output logic [NUM_CHAN-1:0] channelPowerDown
);

  logic [7:0] divCode_q [NUM_CHAN];
  logic [7:0] phase_q [NUM_CHAN];
  logic [NUM_CHAN-1:0] chanPd_q;
  logic [NUM_CHAN-1:0] restart_q;
  logic [NUM_OUT-1:0] outPd_q, style_q, enable_q;
  logic [1:0] amp_q [NUM_OUT];
  logic [7:0] ratioW [NUM_CHAN];
  logic [NUM_CHAN-1:0] divClkW;
  logic [NUM_OUT-1:0] pin_q, format_q, outPdOut_q;
  logic [2*NUM_OUT-1:0] swing_q;
  logic [7:0] rdData_q, rdData_d;
  logic rdValid_q;

  // ==========================================================
  // channel registers: divider, phase, power-down
  always_ff @(posedge clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (!rst_n) begin
        divCode_q[c] <= DIVIDE_RST;
        phase_q[c] <= PHASE_RST;
        chanPd_q[c] <= PD_RST;
      end else if (cfgWrite) begin
        if (cfgAddr == ocdcChanAddr(c, OFF_DIVIDE)) begin
          divCode_q[c] <= cfgWrData;
        end
        if (cfgAddr == ocdcChanAddr(c, OFF_PHASE)) begin
          phase_q[c] <= cfgWrData;
        end
        if (cfgAddr == ocdcChanAddr(c, OFF_CHAN_PD)) begin
          chanPd_q[c] <= cfgWrData[CHAN_PD_BIT];
        end
      end
    end
  end

  // restart a channel one cycle after any write to its divider or phase register
  always_ff @(posedge clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (!rst_n) begin
        restart_q[c] <= 1'b0;
      end else begin
        restart_q[c] <= cfgWrite &&
          (cfgAddr == ocdcChanAddr(c, OFF_DIVIDE) ||
           cfgAddr == ocdcChanAddr(c, OFF_PHASE));
      end
    end
  end

  // ==========================================================
  // output registers: power-down, format, amplitude, enable
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_OUT; i++) begin
      if (!rst_n) begin
        outPd_q[i] <= PD_RST;
        style_q[i] <= STYLE_RST;
        amp_q[i] <= AMP_RST;
        enable_q[i] <= ENABLE_RST;
      end else if (cfgWrite) begin
        if (cfgAddr == ocdcOutAddr(i)) begin
          outPd_q[i] <= cfgWrData[OUT_PD_BIT];
          style_q[i] <= cfgWrData[STYLE_BIT];
          amp_q[i] <= cfgWrData[AMP_LSB+:2];
        end
        if (cfgAddr == ocdcEnAddr(i)) begin
          enable_q[i] <= cfgWrData[ocdcEnBit(i)];
        end
      end
    end
  end

  // ==========================================================
  // read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rdData_d = 8'h00;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (cfgAddr == ocdcChanAddr(c, OFF_DIVIDE)) begin
        rdData_d = divCode_q[c];
      end
      if (cfgAddr == ocdcChanAddr(c, OFF_PHASE)) begin
        rdData_d = phase_q[c];
      end
      if (cfgAddr == ocdcChanAddr(c, OFF_CHAN_PD)) begin
        rdData_d[CHAN_PD_BIT] = chanPd_q[c];
      end
    end
    for (int i = 0; i < NUM_OUT; i++) begin
      if (cfgAddr == ocdcOutAddr(i)) begin
        rdData_d[OUT_PD_BIT] = outPd_q[i];
        rdData_d[STYLE_BIT] = style_q[i];
        rdData_d[AMP_LSB+:2] = amp_q[i];
      end
      if (cfgAddr == ocdcEnAddr(i)) begin
        rdData_d[ocdcEnBit(i)] = enable_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q <= cfgRead ? rdData_d : 8'h00;
      rdValid_q <= cfgRead;
    end
  end

  // ==========================================================
  // channel dividers
  for (genvar c = 0; c < NUM_CHAN; c++) begin : gChan
    assign ratioW[c] = ocdcRatio(divCode_q[c]);
    ocdc_channel_divider uDiv (
      .clk(clk),
      .rst_n(rst_n),
      .restart(restart_q[c]),
      .powerDown(chanPd_q[c]),
      .ratio(ratioW[c]),
      .delay(phase_q[c]),
      .divClk(divClkW[c])
    );
  end

  // ==========================================================
  // output gating and driver settings
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_OUT; i++) begin
      if (!rst_n) begin
        pin_q[i] <= 1'b0;
        outPdOut_q[i] <= 1'b0;
        format_q[i] <= FMT_LOW_VOLT_DIFF;
        swing_q[2*i+:2] <= SWING_250MV;
      end else begin
        pin_q[i] <= enable_q[i] && !outPd_q[i] &&
          !chanPd_q[ocdcOutChan(i)] &&
          divClkW[ocdcOutChan(i)];
        outPdOut_q[i] <= outPd_q[i] || chanPd_q[ocdcOutChan(i)];
        format_q[i] <= style_q[i];
        swing_q[2*i+:2] <= amp_q[i];
      end
    end
  end

  assign clockOutputPin = pin_q;
  assign outputFormat = format_q;
  assign outputSwing = swing_q;
  assign outputPowerDown = outPdOut_q;
  assign channelPowerDown = chanPd_q;
  assign cfgRdData = rdData_q;
  assign cfgRdValid = rdValid_q;

  // ==========================================================
  // checks
  for (genvar i = 0; i < NUM_OUT; i++) begin : gChk
    localparam int CH = ocdcOutChan(i);
    localparam logic [7:0] OADDR = ocdcOutAddr(i);

    chk_enable_low: assert property (@(posedge clk) disable iff (!rst_n)
      !enable_q[i] |=> !clockOutputPin[i])
      else $error("disabled output not held low");

    chk_pass_clock: assert property (@(posedge clk) disable iff (!rst_n)
      enable_q[i] && !outPd_q[i] && !chanPd_q[CH] |=>
      clockOutputPin[i] == $past(divClkW[CH]))
      else $error("enabled output does not follow its channel");

    chk_outpd_gate: assert property (@(posedge clk) disable iff (!rst_n)
      outPd_q[i] |=> outputPowerDown[i] && !clockOutputPin[i])
      else $error("powered down output still active");

    chk_chanpd_gate: assert property (@(posedge clk) disable iff (!rst_n)
      chanPd_q[CH] |=> outputPowerDown[i] && !clockOutputPin[i])
      else $error("channel power-down did not stop its output");

    chk_format_write: assert property (@(posedge clk) disable iff (!rst_n)
      cfgWrite && cfgAddr == OADDR |=> ##1
      outputFormat[i] == $past(cfgWrData[STYLE_BIT], 2))
      else $error("output format does not follow written bit");

    chk_swing_write: assert property (@(posedge clk) disable iff (!rst_n)
      cfgWrite && cfgAddr == OADDR |=> ##1
      outputSwing[2*i+:2] == $past(cfgWrData[AMP_LSB+:2], 2))
      else $error("output swing does not follow written field");
  end

  for (genvar c = 0; c < NUM_CHAN; c++) begin : gChkChan
    localparam logic [7:0] DADDR = ocdcChanAddr(c, OFF_DIVIDE);

    chk_ratio_decode: assert property (@(posedge clk) disable iff (!rst_n)
      cfgWrite && cfgAddr == DADDR |=>
      ratioW[c] == ($past(cfgWrData) == 8'h80 ? 8'h01 :
                    $past(cfgWrData) == 8'h06 ? 8'h08 :
                    $past(cfgWrData) <= 8'h04 ? $past(cfgWrData) + 8'h02 :
                    ratioW[c]))
      else $error("divider code decoded to wrong ratio");
  end

endmodule

// ### verification/ocdc_control_bench.sv
// self-checking bench for the channel and clock output settings block
// assumes ocdc_pkg is compiled first; drives the byte strobe port itself
`timescale 1ns/1ps

`define CHECK(got, exp) begin \
  checksDone++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); \
  end \
end

module ocdc_control_bench
  import ocdc_pkg::*;
;
  // ==========================================================
  // signals and tables
  logic clk;
  logic rst_n;
  logic [7:0] cfgAddr;
  logic [7:0] cfgWrData;
  logic cfgWrite;
  logic cfgRead;
  logic [7:0] cfgRdData;
  logic cfgRdValid;
  logic [NUM_OUT-1:0] clockOutputPin;
  logic [NUM_OUT-1:0] outputFormat;
  logic [2*NUM_OUT-1:0] outputSwing;
  logic [NUM_OUT-1:0] outputPowerDown;
  logic [NUM_CHAN-1:0] channelPowerDown;
  int fails = 0;
  int checksDone = 0;
  int hi;
  int lo;
  int l0;
  int ln;
  localparam logic [7:0] OUT_ADDR [10] = '{8'h24, 8'h25, 8'h26, 8'h34,
    8'h35, 8'h44, 8'h45, 8'h54, 8'h64, 8'h65};
  localparam logic [7:0] DIV_CODE [9] = '{8'h80, 8'h00, 8'h01, 8'h02,
    8'h03, 8'h04, 8'h06, 8'h43, 8'h7E};
  localparam int DIV_RATIO [9] = '{1, 2, 3, 4, 5, 6, 8, 10, 160};
  localparam logic [7:0] PHASES [3] = '{8'h01, 8'h03, 8'hFF};

  ocdc_control dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData),
    .cfgWrite(cfgWrite),
    .cfgRead(cfgRead),
    .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid),
    .clockOutputPin(clockOutputPin),
    .outputFormat(outputFormat),
    .outputSwing(outputSwing),
    .outputPowerDown(outputPowerDown),
    .channelPowerDown(channelPowerDown)
  );

  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    testDone();
  end

  // ==========================================================
  // access tasks
  function automatic logic [7:0] chanAddr(input int c, input logic [7:0] o);
    return 8'(CHAN_BASE + CHAN_STRIDE * 8'(c) + o);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfgAddr = a;
    cfgWrData = d;
    cfgWrite = 1'b1;
    @(negedge clk);
    cfgWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge clk);
    cfgRead = 1'b0;
    `CHECK(cfgRdValid, 1'b1)
    `CHECK(cfgRdData, exp)
    @(negedge clk);
    `CHECK({cfgRdValid, cfgRdData}, 9'h000)
  endtask

  // one output held low while another one still toggles
  task automatic quiet(input int idx, input int other);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk);
      `CHECK(clockOutputPin[idx], 1'b0)
      if (clockOutputPin[other] === 1'b1) seen = 1'b1;
    end
    `CHECK(seen, 1'b1)
  endtask

  // high and low run lengths of one full period
  task automatic measure(input int idx, output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (clockOutputPin[idx] !== 1'b0 && n < 600) begin
      @(negedge clk);
      n++;
    end
    while (clockOutputPin[idx] !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    while (clockOutputPin[idx] === 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
      h++;
    end
    while (clockOutputPin[idx] === 1'b0 && n < 600) begin
      @(negedge clk);
      n++;
      l++;
    end
  endtask

  // cycles from channel power-up to first high on output B0
  task automatic latency(input logic [7:0] d, output int n);
    wr(chanAddr(1, OFF_CHAN_PD), 8'h80);
    repeat (3) @(negedge clk);
    wr(chanAddr(1, OFF_PHASE), d);
    wr(chanAddr(1, OFF_CHAN_PD), 8'h00);
    n = 0;
    while (clockOutputPin[3] !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic testDone;
    if (fails == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    cfgAddr = 8'h00;
    cfgWrData = 8'h00;
    cfgWrite = 1'b0;
    cfgRead = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    // values after reset
    `CHECK(clockOutputPin, 10'h000)
    `CHECK(outputFormat, 10'h000)
    `CHECK(outputSwing, 20'h00000)
    `CHECK(outputPowerDown, 10'h000)
    `CHECK(channelPowerDown, 5'h00)
    for (int c = 0; c < NUM_CHAN; c++) begin
      rd(chanAddr(c, OFF_DIVIDE), 8'h04);
      rd(chanAddr(c, OFF_PHASE), 8'h00);
      rd(chanAddr(c, OFF_CHAN_PD), 8'h00);
    end
    for (int i = 0; i < NUM_OUT; i++) rd(OUT_ADDR[i], 8'h00);
    rd(8'h74, 8'h00);
    rd(8'h75, 8'h00);
    wr(8'h23, 8'hFF);
    rd(8'h23, 8'h00);
    // channel power-down with reserved bits written
    wr(chanAddr(0, OFF_CHAN_PD), 8'hFF);
    rd(chanAddr(0, OFF_CHAN_PD), 8'h80);
    `CHECK(channelPowerDown, 5'h01)
    `CHECK(outputPowerDown, 10'h007)
    wr(8'h74, 8'hFF);
    wr(8'h75, 8'hFF);
    rd(8'h75, 8'h03);
    quiet(0, 3);
    wr(chanAddr(0, OFF_CHAN_PD), 8'h00);
    wr(8'h75, 8'h01);
    quiet(9, 0);
    // output power-down
    wr(OUT_ADDR[0], 8'h80);
    @(negedge clk);
    `CHECK(outputPowerDown, 10'h001)
    quiet(0, 1);
    wr(OUT_ADDR[0], 8'h00);
    // format and swing of every output
    for (int i = 0; i < NUM_OUT; i++) begin
      wr(OUT_ADDR[i], 8'(((i % 2) << 4) | ((i % 4) << 2)));
      @(negedge clk);
      `CHECK(outputFormat[i], 1'(i % 2))
      `CHECK(outputSwing[2*i +: 2], 2'(i % 4))
      rd(OUT_ADDR[i], 8'(((i % 2) << 4) | ((i % 4) << 2)));
    end
    // enable bit cleared holds the output low
    wr(8'h74, 8'h7F);
    quiet(0, 1);
    wr(8'h74, 8'hFF);
    // divider codes on channel A
    for (int k = 0; k < 9; k++) begin
      wr(chanAddr(0, OFF_DIVIDE), DIV_CODE[k]);
      rd(chanAddr(0, OFF_DIVIDE), DIV_CODE[k]);
      if (DIV_RATIO[k] == 1) begin
        repeat (4) @(negedge clk);
        hi = 0;
        repeat (8) begin
          @(negedge clk);
          if (clockOutputPin[0] === 1'b1) hi++;
        end
        `CHECK(hi, 8)
      end else begin
        measure(0, hi, lo);
        `CHECK(hi, (DIV_RATIO[k] + 1) / 2)
        `CHECK(lo, DIV_RATIO[k] / 2)
      end
    end
    // phase delay in whole steps
    latency(8'h00, l0);
    for (int k = 0; k < 3; k++) begin
      latency(PHASES[k], ln);
      `CHECK(ln - l0, int'(PHASES[k]))
      rd(chanAddr(1, OFF_PHASE), PHASES[k]);
    end
    testDone();
  end
endmodule
